/* rtl/ias_pkg.sv */
package ias_pkg;

  // timers count in whole microseconds, advanced by a divided tick
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TIME_UNIT_NS  = 1000;
  localparam int unsigned TICK_CYC      = (TIME_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TICK_W        = 5;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

  localparam logic [7:0] OFF_MODE  = 8'h00;
  localparam logic [7:0] OFF_TSEL  = 8'h04;
  localparam logic [7:0] OFF_TGATE = 8'h08;
  localparam logic [7:0] OFF_TSRC  = 8'h0c;
  localparam logic [7:0] OFF_EXPM  = 8'h10;
  localparam logic [7:0] OFF_EXPT  = 8'h14;
  localparam logic [7:0] OFF_FREN  = 8'h18;
  localparam logic [7:0] OFF_FRPER = 8'h1c;
  localparam logic [7:0] OFF_CMD   = 8'h20;
  localparam logic [7:0] OFF_STAT  = 8'h24;
  localparam logic [7:0] OFF_FCNT  = 8'h28;

  localparam int unsigned FLAG_BIT       = 0;
  localparam int unsigned CMD_START_BIT  = 0;
  localparam int unsigned CMD_STOP_BIT   = 1;
  localparam int unsigned CMD_TRIG_BIT   = 2;
  localparam int unsigned SEL_ACQ_START  = 0;

  localparam logic MODE_SINGLE  = 1'b0;
  localparam logic MODE_CONT    = 1'b1;
  localparam logic SRC_SOFTWARE = 1'b0;
  localparam logic EXPM_TIMED   = 1'b0;

  localparam logic        RST_MODE   = 1'b0;
  localparam logic        RST_TSEL   = 1'b0;
  localparam logic [1:0]  RST_GATE   = 2'h0;
  localparam logic        RST_SRC    = 1'b0;
  localparam logic        RST_EXPM   = 1'b0;
  localparam logic        RST_FR_EN  = 1'b0;
  localparam int unsigned RST_EXP_US = 100;
  localparam int unsigned RST_FR_US  = 50000;

  typedef enum logic [2:0] {IAS_IDLE, IAS_ARMED, IAS_EXPOSE, IAS_XFER, IAS_PACE} ias_state_e;

endpackage

/* rtl/ias_ctl_if.sv */
`timescale 1ns/100ps
interface ias_ctl_if
#(
  parameter int unsigned TW = 20,
  parameter int unsigned FW = 16
);
  logic                acq_cont;
  logic                gate_on;
  logic                src_sw;
  logic                exp_timed;
  logic                fr_en;
  logic [TW-1:0]       exp_us;
  logic [TW-1:0]       fr_us;
  logic                cmd_start;
  logic                cmd_stop;
  logic                cmd_trig;
  ias_pkg::ias_state_e state;
  logic [FW-1:0]       frames;

  modport regs (output acq_cont, gate_on, src_sw, exp_timed, fr_en, exp_us, fr_us,
                output cmd_start, cmd_stop, cmd_trig, input state, frames);
  modport core (input acq_cont, gate_on, src_sw, exp_timed, fr_en, exp_us, fr_us,
                input cmd_start, cmd_stop, cmd_trig, output state, frames);
endinterface

/* rtl/ias_cnt.sv */
`timescale 1ns/100ps
module ias_cnt
#(
  parameter int unsigned W = 20
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              zero
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } ias_cnt_s;

  ias_cnt_s s_q;
  ias_cnt_s s_d;

  if (W < 1)
  begin : g_chk
    $error("ias_cnt width must be at least one");
  end

  always_comb
  begin
    s_d = s_q;
    if (load)
      s_d.cnt = value;
    else if (tick && s_q.cnt != '0)
      s_d.cnt = s_q.cnt - 1'b1;
  end

  assign zero = (s_q.cnt == '0);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule

/* rtl/ias_regs.sv */
`timescale 1ns/100ps
module ias_regs
#(
  parameter int unsigned TW = 20,
  parameter int unsigned FW = 16
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  ias_ctl_if.regs          ctl
);
  typedef struct packed {
    logic          wr;
    logic [7:0]    addr;
    logic          mode;
    logic          tsel;
    logic [1:0]    gate;
    logic          src;
    logic          expm;
    logic [TW-1:0] exp_us;
    logic          fr_en;
    logic [TW-1:0] fr_us;
    logic [2:0]    cmd;
    logic [31:0]   rdata;
  } ias_regs_s;

  localparam ias_regs_s RST = '{wr: 1'b0, addr: 8'h00, mode: ias_pkg::RST_MODE,
    tsel: ias_pkg::RST_TSEL, gate: ias_pkg::RST_GATE, src: ias_pkg::RST_SRC,
    expm: ias_pkg::RST_EXPM, exp_us: TW'(ias_pkg::RST_EXP_US), fr_en: ias_pkg::RST_FR_EN,
    fr_us: TW'(ias_pkg::RST_FR_US), cmd: 3'h0, rdata: 32'h0};

  ias_regs_s s_q;
  ias_regs_s s_d;
  logic      take;

  // read data is caught in the address phase; zero wait states on every access
  always_comb
  begin
    s_d = s_q;
    s_d.cmd = 3'h0;
    take = hsel && hready && htrans[1];
    if (s_q.wr)
    begin
      case (s_q.addr)
        ias_pkg::OFF_MODE:  s_d.mode = hwdata[ias_pkg::FLAG_BIT];
        ias_pkg::OFF_TSEL:  s_d.tsel = hwdata[ias_pkg::FLAG_BIT];
        ias_pkg::OFF_TGATE: s_d.gate[s_q.tsel] = hwdata[ias_pkg::FLAG_BIT];
        ias_pkg::OFF_TSRC:  s_d.src = hwdata[ias_pkg::FLAG_BIT];
        ias_pkg::OFF_EXPM:  s_d.expm = hwdata[ias_pkg::FLAG_BIT];
        ias_pkg::OFF_EXPT:  s_d.exp_us = hwdata[TW-1:0];
        ias_pkg::OFF_FREN:  s_d.fr_en = hwdata[ias_pkg::FLAG_BIT];
        ias_pkg::OFF_FRPER: s_d.fr_us = hwdata[TW-1:0];
        ias_pkg::OFF_CMD:   s_d.cmd = hwdata[2:0];
        default:            s_d.cmd = 3'h0;
      endcase
    end
    s_d.wr = take && hwrite;
    if (take)
      s_d.addr = haddr[7:0];
    if (take && !hwrite)
    begin
      case (haddr[7:0])
        ias_pkg::OFF_MODE:  s_d.rdata = {31'h0, s_q.mode};
        ias_pkg::OFF_TSEL:  s_d.rdata = {31'h0, s_q.tsel};
        ias_pkg::OFF_TGATE: s_d.rdata = {31'h0, s_q.gate[s_q.tsel]};
        ias_pkg::OFF_TSRC:  s_d.rdata = {31'h0, s_q.src};
        ias_pkg::OFF_EXPM:  s_d.rdata = {31'h0, s_q.expm};
        ias_pkg::OFF_EXPT:  s_d.rdata = 32'(s_q.exp_us);
        ias_pkg::OFF_FREN:  s_d.rdata = {31'h0, s_q.fr_en};
        ias_pkg::OFF_FRPER: s_d.rdata = 32'(s_q.fr_us);
        ias_pkg::OFF_STAT:  s_d.rdata = {29'h0, ctl.state};
        ias_pkg::OFF_FCNT:  s_d.rdata = 32'(ctl.frames);
        default:            s_d.rdata = 32'h0;
      endcase
    end
  end

  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = s_q.rdata;
  assign ctl.acq_cont  = (s_q.mode == ias_pkg::MODE_CONT);
  assign ctl.gate_on   = s_q.gate[ias_pkg::SEL_ACQ_START];
  assign ctl.src_sw    = (s_q.src == ias_pkg::SRC_SOFTWARE);
  assign ctl.exp_timed = (s_q.expm == ias_pkg::EXPM_TIMED);
  assign ctl.fr_en     = s_q.fr_en;
  assign ctl.exp_us    = s_q.exp_us;
  assign ctl.fr_us     = s_q.fr_us;
  assign ctl.cmd_start = s_q.cmd[ias_pkg::CMD_START_BIT];
  assign ctl.cmd_stop  = s_q.cmd[ias_pkg::CMD_STOP_BIT];
  assign ctl.cmd_trig  = s_q.cmd[ias_pkg::CMD_TRIG_BIT];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_q <= RST;
    else
      s_q <= s_d;
  end
endmodule

/* rtl/ias_top.sv */
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module ias_top
#(
  parameter int unsigned TW = 20,
  parameter int unsigned FW = 16
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        readout_done,
  output logic             exposure_active,
  output logic             readout_start,
  output logic             xfer_abort
);
  if (TW < 16 || TW > 24)
  begin : g_chk_tw
    $error("ias_top time width must lie in 16..24");
  end
  if (FW < 1 || FW > 32)
  begin : g_chk_fw
    $error("ias_top frame counter width must lie in 1..32");
  end

  ias_ctl_if #(.TW(TW), .FW(FW)) ctl ();

  // only whole-word accesses are expected, so the size is not decoded
  ias_regs #(.TW(TW), .FW(FW)) u_regs
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .ctl       (ctl)
  );

  typedef struct packed {
    ias_pkg::ias_state_e        st;
    logic [ias_pkg::TICK_W-1:0] div;
    logic                       exp_act;
    logic                       rd_start;
    logic                       abort;
    logic [FW-1:0]              frames;
  } ias_core_s;

  ias_core_s     s_q;
  ias_core_s     s_d;
  logic          tick;
  logic          exp_load;
  logic          trig_ok;
  logic          exp_zero;
  logic          pace_zero;
  logic [TW-1:0] pace_us;

  // a disabled limit loads zero, so the pace wait shrinks to a single cycle in IAS_PACE
  assign tick    = (s_q.div == ias_pkg::TICK_LAST);
  assign pace_us = ctl.fr_en ? ctl.fr_us : '0;

  ias_cnt #(.W(TW)) u_exp_cnt
  (
    .clk   (hclk),
    .rst_n (hresetn),
    .tick  (tick),
    .load  (exp_load),
    .value (ctl.exp_us),
    .zero  (exp_zero)
  );

  // frame period is measured from one exposure start to the next
  ias_cnt #(.W(TW)) u_pace_cnt
  (
    .clk   (hclk),
    .rst_n (hresetn),
    .tick  (tick),
    .load  (exp_load),
    .value (pace_us),
    .zero  (pace_zero)
  );

  always_comb
  begin
    s_d = s_q;
    s_d.rd_start = 1'b0;
    s_d.abort = 1'b0;
    exp_load = 1'b0;
    trig_ok = ctl.cmd_trig && ctl.src_sw && ctl.exp_timed;
    if (tick)
      s_d.div = '0;
    else
      s_d.div = s_q.div + 1'b1;
    case (s_q.st)
      ias_pkg::IAS_IDLE:
      begin
        // triggers are simply not looked at here
        if (ctl.cmd_start)
        begin
          if (ctl.gate_on)
            s_d.st = ias_pkg::IAS_ARMED;
          else
            exp_load = 1'b1;
        end
      end
      ias_pkg::IAS_ARMED:
      begin
        if (trig_ok)
          exp_load = 1'b1;
      end
      ias_pkg::IAS_EXPOSE:
      begin
        if (exp_zero)
        begin
          s_d.st = ias_pkg::IAS_XFER;
          s_d.rd_start = 1'b1;
        end
      end
      ias_pkg::IAS_XFER:
      begin
        if (readout_done)
        begin
          s_d.frames = s_q.frames + 1'b1;
          if (ctl.acq_cont)
            s_d.st = ias_pkg::IAS_PACE;
          else
            s_d.st = ias_pkg::IAS_IDLE;
        end
      end
      ias_pkg::IAS_PACE:
      begin
        if (pace_zero)
        begin
          if (ctl.gate_on)
            s_d.st = ias_pkg::IAS_ARMED;
          else
            exp_load = 1'b1;
        end
      end
      default:
      begin
        s_d.st = ias_pkg::IAS_IDLE;
      end
    endcase
    // the load cycle is the first cycle of the first unit, so exposure lasts whole units
    if (exp_load)
    begin
      s_d.st = ias_pkg::IAS_EXPOSE;
      s_d.div = '0;
      s_d.div[0] = 1'b1;
    end
    // stop wins over any start or trigger seen in the same cycle
    if (ctl.cmd_stop)
    begin
      s_d.abort = (s_q.st == ias_pkg::IAS_EXPOSE) || (s_q.st == ias_pkg::IAS_XFER);
      s_d.st = ias_pkg::IAS_IDLE;
      s_d.rd_start = 1'b0;
    end
    s_d.exp_act = (s_d.st == ias_pkg::IAS_EXPOSE);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q.st <= ias_pkg::IAS_IDLE;
      s_q.div <= '0;
      s_q.exp_act <= 1'b0;
      s_q.rd_start <= 1'b0;
      s_q.abort <= 1'b0;
      s_q.frames <= '0;
    end
    else
      s_q <= s_d;
  end

  assign exposure_active = s_q.exp_act;
  assign readout_start   = s_q.rd_start;
  assign xfer_abort      = s_q.abort;
  assign ctl.state       = s_q.st;
  assign ctl.frames      = s_q.frames;

  // checking helpers: exposure length and frame period in clock cycles
  logic [31:0] exp_cyc_q;
  logic [31:0] exp_want_q;
  logic [31:0] per_cyc_q;
  logic [31:0] per_want_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      exp_cyc_q <= 32'h0;
      exp_want_q <= 32'h0;
      per_cyc_q <= 32'h0;
      per_want_q <= 32'h0;
    end
    else
    begin
      if (s_q.st == ias_pkg::IAS_EXPOSE)
        exp_cyc_q <= exp_cyc_q + 32'h1;
      else
        exp_cyc_q <= 32'h0;
      if (exp_load)
      begin
        exp_want_q <= 32'(ctl.exp_us) * ias_pkg::TICK_CYC;
        per_want_q <= 32'(pace_us) * ias_pkg::TICK_CYC;
        per_cyc_q <= 32'h0;
      end
      else if (per_cyc_q != 32'hffffffff)
        per_cyc_q <= per_cyc_q + 32'h1;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_exp_end;
    s_q.st == ias_pkg::IAS_EXPOSE && exp_zero && !ctl.cmd_stop;
  endsequence

  sequence s_xfer_done;
    s_q.st == ias_pkg::IAS_XFER && readout_done && !ctl.cmd_stop;
  endsequence

  property p_ungated_start;
    (s_q.st == ias_pkg::IAS_IDLE && ctl.cmd_start && !ctl.gate_on && !ctl.cmd_stop)
      |=> exposure_active;
  endproperty
  a_ungated_start: assert property (p_ungated_start)
    else $error("ungated start did not open an exposure");

  property p_exp_len;
    s_exp_end |-> (exp_cyc_q + 32'h1 == ((exp_want_q == 32'h0) ? 32'h1 : exp_want_q));
  endproperty
  a_exp_len: assert property (p_exp_len)
    else $error("exposure length differs from the exposure time");

  property p_readout;
    s_exp_end |=> readout_start && !exposure_active ##1 !readout_start;
  endproperty
  a_readout: assert property (p_readout)
    else $error("exposure end did not give one readout start pulse");

  property p_single_once;
    (s_xfer_done and !ctl.acq_cont) |=> s_q.st == ias_pkg::IAS_IDLE && !exposure_active;
  endproperty
  a_single_once: assert property (p_single_once)
    else $error("one-shot acquisition did not return to idle");

  property p_free_run;
    (s_xfer_done and (ctl.acq_cont && !ctl.gate_on && !ctl.fr_en && per_want_q == 32'h0))
      |=> s_q.st == ias_pkg::IAS_PACE ##1 exposure_active;
  endproperty
  a_free_run: assert property (p_free_run)
    else $error("free run did not restart at full rate");

  property p_stop;
    ctl.cmd_stop |=> s_q.st == ias_pkg::IAS_IDLE && !exposure_active && !readout_start;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop left acquisition running");

  property p_stop_abort;
    (ctl.cmd_stop && (s_q.st == ias_pkg::IAS_XFER || s_q.st == ias_pkg::IAS_EXPOSE))
      |=> xfer_abort ##1 !xfer_abort;
  endproperty
  a_stop_abort: assert property (p_stop_abort)
    else $error("stop during a frame gave no abort pulse");

  property p_trig_start;
    (s_q.st == ias_pkg::IAS_ARMED && ctl.cmd_trig && ctl.src_sw && ctl.exp_timed &&
     !ctl.cmd_stop) |=> exposure_active;
  endproperty
  a_trig_start: assert property (p_trig_start)
    else $error("software trigger did not start exposure");

  property p_idle_quiet;
    (s_q.st == ias_pkg::IAS_IDLE && !ctl.cmd_start) |=> s_q.st == ias_pkg::IAS_IDLE;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("idle block left idle without a start");

  property p_gated_arm;
    (s_q.st == ias_pkg::IAS_IDLE && ctl.cmd_start && ctl.gate_on && !ctl.cmd_stop)
      |=> s_q.st == ias_pkg::IAS_ARMED && !exposure_active;
  endproperty
  a_gated_arm: assert property (p_gated_arm)
    else $error("gated start did not arm");

  property p_rate;
    (s_q.st == ias_pkg::IAS_PACE && exp_load) |-> per_cyc_q + 32'h1 >= per_want_q;
  endproperty
  a_rate: assert property (p_rate)
    else $error("frame started before the rate limit period");

  property p_series;
    (s_xfer_done and (ctl.acq_cont && ctl.gate_on)) |=> s_q.st == ias_pkg::IAS_PACE;
  endproperty
  a_series: assert property (p_series)
    else $error("continuous triggered mode did not re-arm");

  property p_gated_drop;
    (s_q.st == ias_pkg::IAS_IDLE && ctl.gate_on && ctl.cmd_trig && !ctl.cmd_start)
      |=> !exposure_active && s_q.st == ias_pkg::IAS_IDLE;
  endproperty
  a_gated_drop: assert property (p_gated_drop)
    else $error("unarmed block took a software trigger");

  property p_armed_wait;
    (s_q.st == ias_pkg::IAS_ARMED && !trig_ok && !ctl.cmd_stop)
      |=> s_q.st == ias_pkg::IAS_ARMED && !exposure_active;
  endproperty
  a_armed_wait: assert property (p_armed_wait)
    else $error("armed block moved without a trigger");
endmodule

/* verif/ias_bench.sv */
`timescale 1ns/100ps
module ias_bench;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        readout_done = 1'b0;
  logic        exposure_active;
  logic        readout_start;
  logic        xfer_abort;
  logic        exp_prev = 1'b0;
  logic [31:0] rd;
  int          errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          n_exp = 0;
  int          n_rs = 0;
  int          n_abort = 0;
  int          len_cnt = 0;
  int          last_len = 0;
  int          rise_last = 0;
  int          rise_prev = 0;

  assign hready = hreadyout;

  ias_top #(.TW(20), .FW(16)) u_ias_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .readout_done(readout_done),
    .exposure_active(exposure_active), .readout_start(readout_start),
    .xfer_abort(xfer_abort));

  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // far side answers every readout one cycle later, so each image is sent before the next
  always @(posedge hclk)
  begin
    cyc          <= cyc + 1;
    exp_prev     <= exposure_active;
    readout_done <= readout_start;
    len_cnt      <= exposure_active ? len_cnt + 1 : 0;
    if (readout_start) n_rs <= n_rs + 1;
    if (xfer_abort) n_abort <= n_abort + 1;
    if (!exposure_active && exp_prev) last_len <= len_cnt;
    if (exposure_active && !exp_prev)
    begin
      n_exp     <= n_exp + 1;
      rise_prev <= rise_last;
      rise_last <= cyc;
    end
  end

  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic miss(input string m);
    errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) miss(m);
  endtask

  task automatic check_bit(input logic got, input logic exp, input string m);
    n_compared++;
    if (got !== exp) miss(m);
  endtask

  task automatic check_cnt(input int got, input int exp, input string m);
    n_compared++;
    if (got != exp) miss(m);
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 64)
      begin
        miss("bus never ready");
        print_verdict();
      end
      @(posedge hclk);
    end
  endtask

  // callers enter right after a rising edge; the address phase goes out at once
  task automatic bus(input logic w, input logic [7:0] off, input logic [31:0] wd);
    haddr  <= {24'h00, off};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] off, input logic [31:0] d);
    bus(1'b1, off, d);
  endtask

  task automatic rdc(input logic [7:0] off, input logic [31:0] exp, input string m);
    bus(1'b0, off, 32'h0);
    check_reg(rd, exp, m);
    check_bit(hresp, 1'b0, "bus response not okay");
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge hclk);
  endtask

  // counters lag one edge behind the design; the bound hides that
  task automatic wait_cnt(ref int c, input int target);
    int n;
    n = 0;
    while (c < target)
    begin
      @(posedge hclk);
      n++;
      if (n > 20000)
      begin
        miss("wait bound ran out");
        print_verdict();
      end
    end
  endtask

  task automatic t_reset;
    rdc(ias_pkg::OFF_MODE, 32'h0, "mode reset");
    rdc(ias_pkg::OFF_TGATE, 32'h0, "gate reset");
    rdc(ias_pkg::OFF_EXPT, 32'h64, "exposure reset");
    rdc(ias_pkg::OFF_FRPER, 32'hc350, "period reset");
    rdc(ias_pkg::OFF_STAT, 32'(ias_pkg::IAS_IDLE), "state reset");
    wr(8'h3c, 32'hffffffff);
    rdc(8'h3c, 32'h0, "unmapped read");
    wr(ias_pkg::OFF_TSEL, 32'h1);
    rdc(ias_pkg::OFF_TSEL, 32'h1, "chooser readback");
    wr(ias_pkg::OFF_TGATE, 32'h1);
    rdc(ias_pkg::OFF_TGATE, 32'h1, "gate of chosen trigger");
    wr(ias_pkg::OFF_TSEL, 32'h0);
    rdc(ias_pkg::OFF_TGATE, 32'h0, "start trigger gate untouched");
    $display("test reset done");
  endtask

  task automatic t_single;
    wr(ias_pkg::OFF_EXPT, 32'h2);
    wr(ias_pkg::OFF_CMD, 32'h1);
    wait_cnt(n_rs, 1);
    check_cnt(last_len, 40, "exposure length");
    idle(300);
    check_cnt(n_exp, 1, "single image count");
    rdc(ias_pkg::OFF_FCNT, 32'h1, "frames sent");
    rdc(ias_pkg::OFF_STAT, 32'(ias_pkg::IAS_IDLE), "single back idle");
    $display("test single done");
  endtask

  task automatic t_free;
    int p;
    wr(ias_pkg::OFF_EXPT, 32'h1);
    wr(ias_pkg::OFF_FRPER, 32'h5);
    wr(ias_pkg::OFF_FREN, 32'h1);
    wr(ias_pkg::OFF_MODE, 32'h1);
    wr(ias_pkg::OFF_CMD, 32'h1);
    wait_cnt(n_exp, n_exp + 3);
    check_cnt(rise_last - rise_prev, 100, "limited period");
    wr(ias_pkg::OFF_FRPER, 32'h0);
    wait_cnt(n_exp, n_exp + 3);
    p = rise_last - rise_prev;
    check_cnt(int'(p > 20 && p <= 24), 1, "limit above max rate");
    wr(ias_pkg::OFF_FREN, 32'h0);
    wait_cnt(n_exp, n_exp + 3);
    p = rise_last - rise_prev;
    check_cnt(int'(p > 20 && p <= 24), 1, "limit disabled");
    wait_cnt(n_exp, n_exp + 1);
    p = n_abort;
    wr(ias_pkg::OFF_CMD, 32'h2);
    idle(4);
    check_cnt(n_abort, p + 1, "stop aborts exposure");
    p = n_exp;
    idle(300);
    check_cnt(n_exp, p, "no image after stop");
    rdc(ias_pkg::OFF_STAT, 32'(ias_pkg::IAS_IDLE), "stopped idle");
    $display("test free run done");
  endtask

  task automatic t_sw_single;
    int b;
    wr(ias_pkg::OFF_MODE, 32'h0);
    wr(ias_pkg::OFF_TGATE, 32'h1);
    b = n_exp;
    wr(ias_pkg::OFF_CMD, 32'h4);
    idle(100);
    check_cnt(n_exp, b, "unarmed trigger dropped");
    wr(ias_pkg::OFF_CMD, 32'h1);
    // the command acts one edge after its write lands
    idle(1);
    rdc(ias_pkg::OFF_STAT, 32'(ias_pkg::IAS_ARMED), "start arms");
    idle(100);
    check_cnt(n_exp, b, "armed waits for trigger");
    wr(ias_pkg::OFF_CMD, 32'h4);
    @(posedge hclk);
    #1;
    check_bit(exposure_active, 1'b1, "trigger starts exposure");
    @(posedge hclk);
    wait_cnt(n_rs, n_rs + 1);
    idle(5);
    wr(ias_pkg::OFF_CMD, 32'h4);
    idle(100);
    check_cnt(n_exp, b + 1, "second trigger ignored");
    wr(ias_pkg::OFF_CMD, 32'h1);
    wr(ias_pkg::OFF_CMD, 32'h4);
    wait_cnt(n_rs, n_rs + 1);
    idle(100);
    check_cnt(n_exp, b + 2, "re-armed takes one");
    $display("test software single done");
  endtask

  task automatic t_sw_cont;
    int b;
    wr(ias_pkg::OFF_MODE, 32'h1);
    wr(ias_pkg::OFF_CMD, 32'h1);
    b = n_exp;
    for (int i = 0; i < 3; i++)
    begin
      idle(30);
      wr(ias_pkg::OFF_CMD, 32'h4);
      wait_cnt(n_rs, n_rs + 1);
    end
    idle(100);
    check_cnt(n_exp, b + 3, "trigger series");
    rdc(ias_pkg::OFF_STAT, 32'(ias_pkg::IAS_ARMED), "series re-arms");
    wr(ias_pkg::OFF_CMD, 32'h2);
    wr(ias_pkg::OFF_CMD, 32'h4);
    idle(100);
    check_cnt(n_exp, b + 3, "trigger after stop");
    // line origin, then width exposure: neither lets a software trigger through
    for (int k = 0; k < 2; k++)
    begin
      wr(ias_pkg::OFF_TSRC, 32'(k == 0));
      wr(ias_pkg::OFF_EXPM, 32'(k == 1));
      wr(ias_pkg::OFF_CMD, 32'h1);
      wr(ias_pkg::OFF_CMD, 32'h4);
      idle(100);
      check_cnt(n_exp, b + 3, "trigger without full setup");
      wr(ias_pkg::OFF_CMD, 32'h2);
    end
    $display("test software series done");
  endtask

  initial
  begin
    #5000000;
    miss("run too long");
    print_verdict();
  end

  initial
  begin
    hresetn = 1'b0;
    hsel    = 1'b1;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_single();
    t_free();
    t_sw_single();
    t_sw_cont();
    print_verdict();
  end
endmodule
